// ===== verilog/tsec_params.svh
// tsec_params.svh: offsets, field positions, reset values and timing counts
// assumes a 50 MHz system clock; register indices are Avalon word addresses
`ifndef TSEC_PARAMS_SVH
`define TSEC_PARAMS_SVH

// register indices (byte address = 4 * index)
`define TSEC_IDX_SCAN_SEL    8'h21
`define TSEC_IDX_SENS_CFG    8'h22
`define TSEC_IDX_HOLD_CFG    8'h23
`define TSEC_IDX_AVG_SAMP    8'h24
`define TSEC_IDX_RECAL       8'h26
`define TSEC_IDX_IRQ_MASK    8'h27
`define TSEC_IDX_RPT_SEL     8'h28
`define TSEC_IDX_MULTI       8'h2a
`define TSEC_IDX_TOUCH_STAT  8'h40
`define TSEC_IDX_EVENT_FLAGS 8'h41
`define TSEC_IDX_SCAN_STAT   8'h42

// reset values
`define TSEC_RST_SCAN_SEL    8'hff
`define TSEC_RST_SENS_CFG    8'ha4
`define TSEC_RST_HOLD_CFG    8'h07
`define TSEC_RST_AVG_SAMP    8'h1d
`define TSEC_RST_RECAL       8'hff
`define TSEC_RST_IRQ_MASK    8'hff
`define TSEC_RST_RPT_SEL     8'hff
`define TSEC_RST_MULTI       8'h80

// field positions
`define TSEC_AVG_MSB         5
`define TSEC_AVG_LSB         3
`define TSEC_SINGLE_SAMPLE_DURATION_BIT   2
`define TSEC_PERIOD_MSB      1
`define TSEC_PERIOD_LSB      0
`define TSEC_RPT_MSB         3
`define TSEC_RPT_LSB         0
`define TSEC_HOLD_MSB        3
`define TSEC_HOLD_LSB        0
`define TSEC_BLOCK_BIT       7
`define TSEC_LIMIT_MSB       3
`define TSEC_LIMIT_LSB       2

// timing: times in ns, counts derived from the clock period
`define TSEC_CLK_NS          20
`define TSEC_T_SAMP_LONG_NS  2560000
`define TSEC_T_SAMP_SHORT_NS 1280000
`define TSEC_T_STEP_NS       35000000
`define TSEC_T_RECAL_NS      600000000
`define TSEC_SAMP_LONG_CYC   (`TSEC_T_SAMP_LONG_NS / `TSEC_CLK_NS)
`define TSEC_SAMP_SHORT_CYC  (`TSEC_T_SAMP_SHORT_NS / `TSEC_CLK_NS)
`define TSEC_STEP_CYC        (`TSEC_T_STEP_NS / `TSEC_CLK_NS)
`define TSEC_RECAL_CYC       (`TSEC_T_RECAL_NS / `TSEC_CLK_NS)

`endif

// ===== verilog/tsec_pkg.sv
// tsec_pkg.sv: types shared by the touch scan and event control block
// assumes tsec_params.svh supplies all numeric constants
package tsec_pkg;

  typedef enum logic [2:0] {
    TSEC_SCAN_IDLE   = 3'b001,
    TSEC_SCAN_NEXT   = 3'b010,
    TSEC_SCAN_SAMPLE = 3'b100
  } tsec_scan_t;

  typedef logic [7:0] tsec_chmask_t;

endpackage

// ===== verilog/tsec_avg.sv
// tsec_avg.sv: per-channel sample accumulator with power-of-two averaging
// assumes samples arrive as single-cycle strobes on the system clock
`timescale 1ns/1ps
`default_nettype none

module tsec_avg #(
  parameter int RAW_W = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // sample side
  input  wire logic             add_en,
  input  wire logic             first,
  input  wire logic             last,
  input  wire logic [2:0]       shift,
  input  wire logic [RAW_W-1:0] raw,
  // result side
  output logic      [RAW_W-1:0] avg_ff,
  output logic                  avg_valid_ff
);

  logic [RAW_W+6:0] acc_ff;
  logic [RAW_W+6:0] nxt_acc;

  always_comb begin
    nxt_acc = (first ? '0 : acc_ff) + {7'h00, raw};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_ff <= '0;
    end else if (add_en) begin
      acc_ff <= nxt_acc;
    end
  end

  // shift instead of divide: counts are powers of two
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avg_ff       <= '0;
      avg_valid_ff <= 1'b0;
    end else begin
      avg_valid_ff <= add_en & last;
      if (add_en & last) begin
        avg_ff <= RAW_W'(nxt_acc >> shift);
      end
    end
  end

endmodule // tsec_avg

`default_nettype wire

// ===== verilog/tsec_top.sv
// tsec_top.sv: scan sequencing, forced recalibration, touch events, blocking
// assumes touch detection and raw sample values come from same-clock logic
`include "tsec_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tsec_top
  import tsec_pkg::*;
#(
  parameter int RAW_W = 16,
  parameter logic [31:0] SAMP_LONG_CYC  = 32'(`TSEC_SAMP_LONG_CYC),
  parameter logic [31:0] SAMP_SHORT_CYC = 32'(`TSEC_SAMP_SHORT_CYC),
  parameter logic [31:0] STEP_CYC       = 32'(`TSEC_STEP_CYC),
  parameter logic [31:0] RECAL_CYC      = 32'(`TSEC_RECAL_CYC)
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // avalon-mm slave
  input  wire logic [7:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [3:0]         avs_byteenable,
  input  wire logic [31:0]        avs_writedata,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  // measurement front end
  input  wire tsec_pkg::tsec_chmask_t sense_input,
  input  wire logic [RAW_W-1:0]   raw_sample,
  output logic                    sample_active,
  output logic      [2:0]         sample_channel,
  output logic                    low_power_idle,
  // results
  output logic      [RAW_W-1:0]   meas_result,
  output logic      [2:0]         meas_channel,
  output logic                    meas_valid,
  output tsec_pkg::tsec_chmask_t  base_invalid,
  // interrupt pin
  output logic                    irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and bus

  tsec_chmask_t scan_sel_ff, recal_ff, mask_ff, rpt_sel_ff, flags_ff;
  tsec_chmask_t acc_ff, nxt_acc, evt, recal_ok;
  logic [7:0]   sens_cfg_ff, hold_cfg_ff, avg_samp_ff, multi_ff;
  logic         ack_ff;
  logic [31:0]  rdata_ff;
  logic [7:0]   rd_byte;
  logic         wr_now;
  logic         irq_ff;
  logic         extended_ff;

  function automatic logic [4:0] steps(input logic [3:0] code);
    steps = {1'b0, code} + 5'h01;
  endfunction

  function automatic logic [3:0] popcnt(input tsec_chmask_t v);
    popcnt = 4'h0;
    for (int i = 0; i < 8; i++) begin
      popcnt = popcnt + {3'h0, v[i]};
    end
  endfunction

  // one wait state: answer at the second edge of each request
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata    = rdata_ff;
  assign wr_now          = avs_write & ack_ff & avs_byteenable[0];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
  end

  always_comb begin
    case (avs_address)
      `TSEC_IDX_SCAN_SEL:    rd_byte = scan_sel_ff;
      `TSEC_IDX_SENS_CFG:    rd_byte = sens_cfg_ff;
      `TSEC_IDX_HOLD_CFG:    rd_byte = hold_cfg_ff;
      `TSEC_IDX_AVG_SAMP:    rd_byte = avg_samp_ff;
      `TSEC_IDX_RECAL:       rd_byte = recal_ff;
      `TSEC_IDX_IRQ_MASK:    rd_byte = mask_ff;
      `TSEC_IDX_RPT_SEL:     rd_byte = rpt_sel_ff;
      `TSEC_IDX_MULTI:       rd_byte = multi_ff;
      `TSEC_IDX_TOUCH_STAT:  rd_byte = acc_ff;
      `TSEC_IDX_EVENT_FLAGS: rd_byte = flags_ff;
      `TSEC_IDX_SCAN_STAT:   rd_byte = {5'h00, extended_ff, low_power_idle, sample_active};
      default:               rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read & ~ack_ff) begin
      rdata_ff <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scan_sel_ff <= `TSEC_RST_SCAN_SEL;
      sens_cfg_ff <= `TSEC_RST_SENS_CFG;
      hold_cfg_ff <= `TSEC_RST_HOLD_CFG;
      avg_samp_ff <= `TSEC_RST_AVG_SAMP;
      mask_ff     <= `TSEC_RST_IRQ_MASK;
      rpt_sel_ff  <= `TSEC_RST_RPT_SEL;
      multi_ff    <= `TSEC_RST_MULTI;
    end else if (wr_now) begin
      case (avs_address)
        `TSEC_IDX_SCAN_SEL: scan_sel_ff <= avs_writedata[7:0];
        `TSEC_IDX_SENS_CFG: sens_cfg_ff <= avs_writedata[7:0];
        `TSEC_IDX_HOLD_CFG: hold_cfg_ff <= {4'h0, avs_writedata[3:0]};
        `TSEC_IDX_AVG_SAMP: avg_samp_ff <= {2'b00, avs_writedata[5:0]};
        `TSEC_IDX_IRQ_MASK: mask_ff     <= avs_writedata[7:0];
        `TSEC_IDX_RPT_SEL:  rpt_sel_ff  <= avs_writedata[7:0];
        `TSEC_IDX_MULTI:    multi_ff    <= {avs_writedata[7], 3'h0, avs_writedata[3:2], 2'h0};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 35 ms step tick, shared by hold and repeat timing; the period keeps its own step count in pcyc_ff

  logic [31:0] step_cnt_ff;
  logic        tick;

  assign tick = (step_cnt_ff == STEP_CYC - 32'h1);

  always_ff @(posedge clk_sys) begin
    if (rst || tick) begin
      step_cnt_ff <= 32'h0;
    end else begin
      step_cnt_ff <= step_cnt_ff + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan sequencer

  tsec_scan_t  scan_ff;
  logic [2:0]  ch_ff;
  logic [7:0]  samp_idx_ff;
  logic [31:0] dur_ff, pcyc_ff, dur_end;
  logic [2:0]  pticks_ff;
  logic        period_done_ff, samp_end, samp_last, scan_start;
  logic [7:0]  samp_total;

  assign samp_total = 8'h01 << avg_samp_ff[`TSEC_AVG_MSB:`TSEC_AVG_LSB];
  assign dur_end    = avg_samp_ff[`TSEC_SINGLE_SAMPLE_DURATION_BIT] ?
                      SAMP_SHORT_CYC : SAMP_LONG_CYC;
  assign samp_end   = (scan_ff == TSEC_SCAN_SAMPLE) && (dur_ff == dur_end - 32'h1);
  assign samp_last  = samp_idx_ff >= samp_total - 8'h01; // a count cut mid-channel still ends
  // a stretched period restarts as soon as sampling is done
  assign scan_start = (scan_ff == TSEC_SCAN_IDLE) && period_done_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scan_ff     <= TSEC_SCAN_IDLE;
      ch_ff       <= 3'h0;
      samp_idx_ff <= 8'h00;
      dur_ff      <= 32'h0;
    end else begin
      case (scan_ff)
        TSEC_SCAN_IDLE: begin
          if (scan_start) begin
            ch_ff   <= 3'h0;
            scan_ff <= TSEC_SCAN_NEXT;
          end
        end
        TSEC_SCAN_NEXT: begin
          samp_idx_ff <= 8'h00;
          dur_ff      <= 32'h0;
          if (scan_sel_ff[ch_ff]) begin
            scan_ff <= TSEC_SCAN_SAMPLE;
          end else if (ch_ff == 3'h7) begin
            scan_ff <= TSEC_SCAN_IDLE;
          end else begin
            ch_ff <= ch_ff + 3'h1;
          end
        end
        TSEC_SCAN_SAMPLE: begin
          dur_ff <= samp_end ? 32'h0 : dur_ff + 32'h1;
          if (samp_end) begin
            samp_idx_ff <= samp_idx_ff + 8'h01;
            if (samp_last) begin
              if (ch_ff == 3'h7) begin
                scan_ff <= TSEC_SCAN_IDLE;
              end else begin
                ch_ff   <= ch_ff + 3'h1;
                scan_ff <= TSEC_SCAN_NEXT;
              end
            end
          end
        end
        default: scan_ff <= TSEC_SCAN_IDLE;
      endcase
    end
  end

  // period length counted in steps from each scan start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pcyc_ff        <= 32'h0;
      pticks_ff      <= 3'h0;
      period_done_ff <= 1'b1;
      extended_ff    <= 1'b0;
    end else if (scan_start) begin
      pcyc_ff        <= 32'h0;
      pticks_ff      <= 3'h0;
      period_done_ff <= 1'b0;
      extended_ff    <= 1'b0;
    end else if (!period_done_ff) begin
      pcyc_ff <= (pcyc_ff == STEP_CYC - 32'h1) ? 32'h0 : pcyc_ff + 32'h1;
      if (pcyc_ff == STEP_CYC - 32'h1) begin
        pticks_ff <= pticks_ff + 3'h1;
        if (pticks_ff == {1'b0, avg_samp_ff[`TSEC_PERIOD_MSB:`TSEC_PERIOD_LSB]}) begin
          period_done_ff <= 1'b1;
          extended_ff    <= scan_ff != TSEC_SCAN_IDLE;
        end
      end
    end
  end

  assign sample_active  = scan_ff == TSEC_SCAN_SAMPLE;
  assign sample_channel = ch_ff;
  assign low_power_idle = scan_ff == TSEC_SCAN_IDLE;

  tsec_avg #(
    .RAW_W (RAW_W)
  ) u_avg (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .add_en       (samp_end),
    .first        (samp_idx_ff == 8'h00),
    .last         (samp_last),
    .shift        (avg_samp_ff[`TSEC_AVG_MSB:`TSEC_AVG_LSB]),
    .raw          (raw_sample),
    .avg_ff       (meas_result),
    .avg_valid_ff (meas_valid)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meas_channel <= 3'h0;
    end else if (samp_end & samp_last) begin
      meas_channel <= ch_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // forced recalibration

  logic [31:0] recal_cnt_ff [8];

  // a press restarts the wait, so a disturbed run never counts as done
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        recal_cnt_ff[i] <= 32'h0;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (!recal_ff[i] || sense_input[i] || recal_ok[i]) begin
          recal_cnt_ff[i] <= 32'h0;
        end else begin
          recal_cnt_ff[i] <= recal_cnt_ff[i] + 32'h1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      recal_ok[i] = recal_ff[i] && !sense_input[i] &&
                    (recal_cnt_ff[i] == RECAL_CYC - 32'h1);
    end
  end

  // a software write of one beats the self-clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      recal_ff <= `TSEC_RST_RECAL;
    end else begin
      recal_ff <= (recal_ff & ~recal_ok) |
                  ((wr_now && avs_address == `TSEC_IDX_RECAL) ?
                   avs_writedata[7:0] : 8'h00);
    end
  end

  assign base_invalid = recal_ff;

  ////////////////////////////////////////////////////////////////////////////
  // touch acceptance and multi-touch blocking

  tsec_chmask_t touch_q;
  logic [3:0]   taken;
  logic [3:0]   limit;

  assign touch_q = sense_input & scan_sel_ff & ~recal_ff;
  assign limit   = {2'b00, multi_ff[`TSEC_LIMIT_MSB:`TSEC_LIMIT_LSB]} + 4'h1;

  always_comb begin
    nxt_acc = acc_ff & touch_q;
    taken   = popcnt(nxt_acc);
    for (int i = 0; i < 8; i++) begin
      if (touch_q[i] && !nxt_acc[i] &&
          (!multi_ff[`TSEC_BLOCK_BIT] || taken < limit)) begin
        nxt_acc[i] = 1'b1;
        taken      = taken + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_ff <= 8'h00;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // touch, release and repeat events

  logic [4:0]   held_ff [8];
  logic [4:0]   rpt_ff  [8];
  tsec_chmask_t hold_ff;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      evt[i] = nxt_acc[i] & ~acc_ff[i];
      if (acc_ff[i] & ~nxt_acc[i] & ~(rpt_sel_ff[i] & hold_ff[i])) begin
        evt[i] = 1'b1;
      end
      if (acc_ff[i] & nxt_acc[i] & hold_ff[i] & tick &&
          rpt_ff[i] + 5'h01 == steps(sens_cfg_ff[`TSEC_RPT_MSB:`TSEC_RPT_LSB])) begin
        evt[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_ff <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        held_ff[i] <= 5'h00;
        rpt_ff[i]  <= 5'h00;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (!acc_ff[i] || !nxt_acc[i]) begin
          held_ff[i] <= 5'h00;
          rpt_ff[i]  <= 5'h00;
          hold_ff[i] <= 1'b0;
        end else if (tick) begin
          if (held_ff[i] != 5'h1f) begin
            held_ff[i] <= held_ff[i] + 5'h01;
          end
          // held past the hold time: switch to repeating
          if (rpt_sel_ff[i] && !hold_ff[i] &&
              held_ff[i] == steps(hold_cfg_ff[`TSEC_HOLD_MSB:`TSEC_HOLD_LSB])) begin
            hold_ff[i] <= 1'b1;
          end
          if (hold_ff[i]) begin
            rpt_ff[i] <= evt[i] ? 5'h00 : rpt_ff[i] + 5'h01;
          end
        end
      end
    end
  end

  // sticky flags cleared by writing one; a new event wins over the clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_ff <= 8'h00;
      irq_ff   <= 1'b0;
    end else begin
      flags_ff <= (flags_ff & ~((wr_now && avs_address == `TSEC_IDX_EVENT_FLAGS) ?
                  avs_writedata[7:0] : 8'h00)) | evt;
      irq_ff   <= |(((flags_ff & ~((wr_now && avs_address == `TSEC_IDX_EVENT_FLAGS) ?
                  avs_writedata[7:0] : 8'h00)) | evt) & mask_ff);
    end
  end

  assign irq_out = irq_ff;

endmodule // tsec_top

`default_nettype wire

// ===== tb/tsec_checker.sv
// tsec_checker.sv: port-level assertions for tsec_top
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module tsec_checker
  import tsec_pkg::*;
#(
  parameter int          RAW_W     = 16,
  parameter logic [31:0] RECAL_CYC = 32'd30
) (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rst,
  // avalon-mm
  input wire logic [7:0]             avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [3:0]             avs_byteenable,
  input wire logic [31:0]            avs_writedata,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  // front end and results
  input wire tsec_pkg::tsec_chmask_t sense_input,
  input wire logic [RAW_W-1:0]       raw_sample,
  input wire logic                   sample_active,
  input wire logic [2:0]             sample_channel,
  input wire logic                   low_power_idle,
  input wire logic [RAW_W-1:0]       meas_result,
  input wire logic [2:0]             meas_channel,
  input wire logic                   meas_valid,
  input wire tsec_pkg::tsec_chmask_t base_invalid,
  input wire logic                   irq_out
);
  // cycles channel 0 has gone without a press; a press restarts recal
  logic [31:0] quiet0_ff;

  always_ff @(posedge clk_sys) begin
    if (rst || sense_input[0]) quiet0_ff <= '0;
    else quiet0_ff <= quiet0_ff + 32'd1;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_req_open;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  a_bus_one_wait: assert property (s_req_open |-> s_one_wait)
    else $error("bus request not answered after one wait state");
  a_bus_ready_bound: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
    else $error("bus request left waiting");
  a_rdata_upper_zero: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_unmapped_read: assert property (avs_read && !avs_waitrequest && avs_address == 8'h30
    |-> avs_readdata == 32'h0)
    else $error("unmapped read returned data");
  a_valid_pulse: assert property (meas_valid |=> !meas_valid)
    else $error("result strobe longer than one cycle");
  a_idle_excl: assert property (!(sample_active && low_power_idle))
    else $error("idle while sampling");
  a_reset_exit: assert property ($fell(rst) |-> base_invalid == 8'hff && !irq_out && !meas_valid)
    else $error("wrong state after reset");
  a_recal_quiet: assert property ($fell(base_invalid[0]) |-> quiet0_ff >= RECAL_CYC)
    else $error("recalibration finished despite press");
  a_result_channel: assert property (meas_valid |-> meas_channel == $past(sample_channel)
    && $past(sample_active))
    else $error("result channel differs from sampled channel");
endmodule // tsec_checker

bind tsec_top tsec_checker #(.RAW_W(RAW_W), .RECAL_CYC(RECAL_CYC)) tsec_checker_inst (
  .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sense_input(sense_input), .raw_sample(raw_sample), .sample_active(sample_active),
  .sample_channel(sample_channel), .low_power_idle(low_power_idle),
  .meas_result(meas_result), .meas_channel(meas_channel), .meas_valid(meas_valid),
  .base_invalid(base_invalid), .irq_out(irq_out));

`default_nettype wire

// ===== tb/tsec_front_model.sv
// tsec_front_model.sv: measurement front end giving a fixed value per channel
// assumes raw_sample is taken only while sample_active is high
`timescale 1ns/1ps
`default_nettype none

module tsec_front_model #(
  parameter int RAW_W = 16
) (
  // sequencer side
  input wire logic              clk_sys,
  input wire logic              sample_active,
  input wire logic [2:0]        sample_channel,
  // sample out
  output logic      [RAW_W-1:0] raw_sample
);
  // outside a slot the value stays at zero, as junk_ff only negates its zero start
  logic [RAW_W-1:0] junk_ff = '0;

  always_ff @(posedge clk_sys) begin
    junk_ff <= ~junk_ff + RAW_W'(1);
  end

  assign raw_sample = sample_active ?
    RAW_W'(16'h0100 + 16'(sample_channel) * 16'h0011) : junk_ff;
endmodule // tsec_front_model

`default_nettype wire

// ===== tb/touch_scan_event_control_test.sv
// touch_scan_event_control_test.sv: register and event tests for tsec_top
// assumes shortened timing parameters and a 50 MHz clock
`timescale 1ns/1ps
`default_nettype none

module touch_scan_event_control_test;
  import tsec_pkg::*;

  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  logic [7:0]   avs_address = 8'h0;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0;
  logic [3:0]   avs_byteenable = 4'h1;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  tsec_chmask_t sense_r = 8'h0;
  tsec_chmask_t base_invalid;
  logic [15:0]  raw_sample, meas_result;
  logic [2:0]   sample_channel, meas_channel;
  logic         sample_active, low_power_idle, meas_valid, irq_out;
  int           err_total = 0;
  int           n_checks = 0;

  always #10 clk_sys = ~clk_sys;

  tsec_top #(.SAMP_LONG_CYC(32'd8), .SAMP_SHORT_CYC(32'd4), .STEP_CYC(32'd20),
    .RECAL_CYC(32'd30)) tsec_top_inst (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sense_input(sense_r), .raw_sample(raw_sample), .sample_active(sample_active),
    .sample_channel(sample_channel), .low_power_idle(low_power_idle),
    .meas_result(meas_result), .meas_channel(meas_channel), .meas_valid(meas_valid),
    .base_invalid(base_invalid), .irq_out(irq_out));

  tsec_front_model tsec_front_model_inst (.clk_sys(clk_sys), .sample_active(sample_active),
    .sample_channel(sample_channel), .raw_sample(raw_sample));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer; an edge always passes before the next request
  task automatic bus_go(input logic [7:0] a, input logic wr, input logic [7:0] d,
                        output logic [31:0] q);
    int n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    // waitrequest settles before the falling edge and stands to the next rise
    do begin
      @(negedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    @(posedge clk_sys);
    q = avs_readdata;
    if (n >= 20) err_total++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus_go(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus_go(a, 1'b0, 8'h0, q);
    chk(q, {24'h0, exp});
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hold(20000);
    err_total++;
    give_verdict();
  end

  initial begin
    logic [7:0] ra [5] = '{8'h24, 8'h26, 8'h27, 8'h28, 8'h2a};
    logic [7:0] rv [5] = '{8'h1d, 8'hff, 8'hff, 8'hff, 8'h80};
    int n;
    hold(16);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(ra[i], rv[i]);
    rd(8'h30, 8'h00);
    // a write without byte lane 0 must leave the register alone
    avs_byteenable <= 4'h0;
    wr(8'h27, 8'h00);
    avs_byteenable <= 4'h1;
    rd(8'h27, 8'hff);
    hold(40);
    rd(8'h26, 8'h00);
    // only channel 2 scanned, two long samples, shortest period
    wr(8'h21, 8'h04);
    wr(8'h24, 8'h08);
    // let the scan begun under the old settings run out first
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (low_power_idle !== 1'b1 && n < 300);
    if (n >= 300) err_total++;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (meas_valid !== 1'b1 && n < 300);
      if (n >= 300) err_total++;
      chk({29'h0, meas_channel}, 32'h2);
      chk({16'h0, meas_result}, 32'h0122);
    end
    wr(8'h21, 8'hff);
    // press during recal keeps the trigger bit set
    wr(8'h26, 8'h01);
    sense_r <= 8'h01;
    hold(45);
    rd(8'h26, 8'h01);
    chk({24'h0, base_invalid}, 32'h01);
    sense_r <= 8'h00;
    hold(45);
    rd(8'h26, 8'h00);
    wr(8'h41, 8'hff);
    // masked channel flags but keeps the pin quiet
    wr(8'h27, 8'h00);
    wr(8'h28, 8'h00);
    sense_r <= 8'h08;
    hold(10);
    chk({31'h0, irq_out}, 32'h0);
    rd(8'h41, 8'h08);
    sense_r <= 8'h00;
    hold(10);
    wr(8'h41, 8'hff);
    wr(8'h27, 8'hff);
    // repeat off: one event each on touch and release
    sense_r <= 8'h08;
    hold(10);
    chk({31'h0, irq_out}, 32'h1);
    wr(8'h41, 8'hff);
    hold(100);
    chk({31'h0, irq_out}, 32'h0);
    sense_r <= 8'h00;
    hold(10);
    chk({31'h0, irq_out}, 32'h1);
    wr(8'h41, 8'hff);
    // repeat on, short touch
    wr(8'h28, 8'hff);
    wr(8'h23, 8'h03);
    wr(8'h22, 8'h00);
    sense_r <= 8'h08;
    hold(10);
    rd(8'h41, 8'h08);
    wr(8'h41, 8'hff);
    sense_r <= 8'h00;
    hold(10);
    rd(8'h41, 8'h08);
    wr(8'h41, 8'hff);
    // repeat on, held past the hold time
    wr(8'h23, 8'h00);
    sense_r <= 8'h08;
    hold(10);
    wr(8'h41, 8'hff);
    hold(70);
    rd(8'h41, 8'h08);
    // a long interval keeps repeats away from the release
    wr(8'h22, 8'h0f);
    wr(8'h41, 8'hff);
    sense_r <= 8'h00;
    hold(5);
    rd(8'h41, 8'h00);
    // blocking with limits one and two, then off
    sense_r <= 8'h01;
    hold(5);
    sense_r <= 8'h03;
    hold(5);
    rd(8'h40, 8'h01);
    sense_r <= 8'h00;
    wr(8'h2a, 8'h84);
    sense_r <= 8'h01;
    hold(5);
    sense_r <= 8'h07;
    hold(5);
    rd(8'h40, 8'h03);
    sense_r <= 8'h00;
    wr(8'h2a, 8'h04);
    sense_r <= 8'h07;
    hold(5);
    rd(8'h40, 8'h07);
    give_verdict();
  end
endmodule // touch_scan_event_control_test

`default_nettype wire
